/* rtl/pfi_cfg.svh */
// Purpose: offsets, field positions, reset values for the fault event block
// Assumes: apb byte addressing, index times four
// Notes:   definitions only
`ifndef PFI_CFG_SVH
`define PFI_CFG_SVH
// register indices as printed
`define PFI_IDX_OV_WARN_CFG   8'h10
`define PFI_IDX_RST_MASK      8'h11
`define PFI_IDX_EVT_FLAGS     8'h12
`define PFI_IDX_EVT_MASK      8'h13
// byte addresses
`define PFI_ADDR_OV_WARN_CFG  12'h040
`define PFI_ADDR_RST_MASK     12'h044
`define PFI_ADDR_EVT_FLAGS    12'h048
`define PFI_ADDR_EVT_MASK     12'h04C
// field positions
`define PFI_OV_SEL_BIT        7
`define PFI_EVT_LSB           2
`define PFI_EVT_MSB           7
// reset values
`define PFI_RST_OV_WARN_CFG   8'h00
`define PFI_RST_RST_MASK      8'h00
`define PFI_RST_EVT_FLAGS     8'h00
`define PFI_RST_EVT_MASK      8'h00
`endif

/* rtl/pfi_pkg.sv */
// Purpose: shared types for the fault event block
// Assumes: nothing
// Notes:   offsets live in pfi_cfg.svh
package pfi_pkg;
  typedef logic [7:0] pfi_byte_t;
  typedef logic [5:0] pfi_evt_t;
  typedef enum logic [0:0] {PFI_OV_LVL_LOW, PFI_OV_LVL_HIGH} pfi_ov_lvl_t;
endpackage

/* rtl/pfi_evt_flag.sv */
// Purpose: one sticky write-one-to-clear event flag
// Assumes: condition level synchronous to pclk
// Notes:   set wins over clear; clear only once the condition is gone
`timescale 1ns/100ps
module pfi_evt_flag
  import pfi_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // event
  input  wire logic cond,
  input  wire logic clr,
  output logic      flag
);
  logic flag_ff;
  logic nxt_flag;

  always_comb begin
    nxt_flag = flag_ff;
    if (clr && !cond)
      nxt_flag = 1'b0;
    if (cond)
      nxt_flag = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      flag_ff <= 1'b0;
    else
      flag_ff <= nxt_flag;
  end

  assign flag = flag_ff;
endmodule

/* rtl/pfi_reset_gate.sv */
// Purpose: combine unmasked protective fault requests into reset request
// Assumes: fault levels synchronous to pclk
// Notes:   registered so the reset pin comes from a flip-flop
`timescale 1ns/100ps
module pfi_reset_gate
  import pfi_pkg::*;
(
  // clock and reset
  input  wire logic      pclk,
  input  wire logic      presetn,
  // faults and mask
  input  wire pfi_byte_t fault,
  input  wire pfi_byte_t block,
  output logic           rst_req
);
  logic rst_req_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rst_req_ff <= 1'b0;
    else
      rst_req_ff <= |(fault & ~block);
  end

  assign rst_req = rst_req_ff;
endmodule

/* rtl/pfi_fault_irq.sv */
// Purpose: fault event flags, interrupt and reset masking with apb slave
// Assumes: event and fault inputs are synchronous levels
// Notes:   unmapped addresses read zero with pslverr
`timescale 1ns/100ps
`include "pfi_cfg.svh"

// Summary of operation
// - ov_warning_threshold_cfg bit 7 selects the upper warning level, 0 low, 1 high
// - eight reset block bits; a 1 keeps that fault from pulling reset
// - reset blocking only gates the reset request; fault inputs record no flag
// - six event flags sit in bits 7 to 2 and read 1 after the event
// - writing 1 clears a flag only when its condition is gone; 0 does nothing
// - each event has an interrupt mask bit at the same position
// - interrupt masking never stops a flag being set and held
module pfi_fault_irq
  import pfi_pkg::*;
(
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // event conditions: 5 monitor low,4 warning low,3 upper warning,2 ov,1 ot,0 out fault
  input  wire pfi_evt_t    event_cond,
  // protective faults: b1,b2,b3,b4,l1,l2,input ov,ot
  input  wire pfi_byte_t   fault_cond,
  // outputs
  output logic             upper_ov_warn_level_select,
  output logic             interrupt_out_n,
  output logic             system_reset_out_n
);
  pfi_byte_t   ov_cfg_ff;
  pfi_byte_t   rst_mask_ff;
  pfi_byte_t   evt_mask_ff;
  logic [31:0] prdata_ff;
  logic        pslverr_ff;
  logic        irq_n_ff;
  logic        ov_sel_ff;
  pfi_evt_t    evt_flag;
  pfi_evt_t    evt_clr;
  logic        rst_req;
  logic        wr_en;
  logic        ok;
  pfi_byte_t   nxt_rdata;

  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == `PFI_ADDR_OV_WARN_CFG) || (a == `PFI_ADDR_RST_MASK) ||
               (a == `PFI_ADDR_EVT_FLAGS) || (a == `PFI_ADDR_EVT_MASK);
  endfunction

  // zero wait state slave
  assign wr_en = psel && penable && pwrite && pstrb[0];
  assign ok    = addr_hit(paddr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ov_cfg_ff <= `PFI_RST_OV_WARN_CFG;
    else if (wr_en && paddr == `PFI_ADDR_OV_WARN_CFG)
      ov_cfg_ff <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rst_mask_ff <= `PFI_RST_RST_MASK;
    else if (wr_en && paddr == `PFI_ADDR_RST_MASK)
      rst_mask_ff <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      evt_mask_ff <= `PFI_RST_EVT_MASK;
    else if (wr_en && paddr == `PFI_ADDR_EVT_MASK)
      evt_mask_ff <= {pwdata[`PFI_EVT_MSB:`PFI_EVT_LSB], 2'b00};
  end

  // flags set regardless of either mask
  assign evt_clr = (wr_en && paddr == `PFI_ADDR_EVT_FLAGS) ? pwdata[`PFI_EVT_MSB:`PFI_EVT_LSB] : 6'h00;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_flag
      pfi_evt_flag u_flag (
        .pclk    (pclk),
        .presetn (presetn),
        .cond    (event_cond[gi]),
        .clr     (evt_clr[gi]),
        .flag    (evt_flag[gi])
      );
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq_n_ff <= 1'b1;
    else
      irq_n_ff <= ~|(evt_flag & ~evt_mask_ff[`PFI_EVT_MSB:`PFI_EVT_LSB]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ov_sel_ff <= 1'b0;
    else
      ov_sel_ff <= ov_cfg_ff[`PFI_OV_SEL_BIT];
  end

  pfi_reset_gate u_rst (
    .pclk    (pclk),
    .presetn (presetn),
    .fault   (fault_cond),
    .block   (rst_mask_ff),
    .rst_req (rst_req)
  );

  always_comb begin
    nxt_rdata = 8'h00;
    unique case (paddr)
      `PFI_ADDR_OV_WARN_CFG: nxt_rdata = ov_cfg_ff;
      `PFI_ADDR_RST_MASK:    nxt_rdata = rst_mask_ff;
      `PFI_ADDR_EVT_FLAGS:   nxt_rdata = {evt_flag, 2'b00};
      `PFI_ADDR_EVT_MASK:    nxt_rdata = evt_mask_ff;
      default:               nxt_rdata = 8'h00;
    endcase
  end

  // read data registered at setup so it stands in access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata_ff <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata_ff <= {24'h00_0000, nxt_rdata};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pslverr_ff <= 1'b0;
    else if (psel && !penable)
      pslverr_ff <= !ok;
  end

  assign prdata                     = prdata_ff;
  assign pready                     = 1'b1;
  assign pslverr                    = pslverr_ff;
  assign interrupt_out_n            = irq_n_ff;
  assign system_reset_out_n         = ~rst_req;
  assign upper_ov_warn_level_select = ov_sel_ff;
endmodule

/* tb/pfi_fault_irq_props.sv */
// Purpose: port assertions for pfi_fault_irq
// Assumes: one pclk domain
// Notes: masks mirrored from bus writes
`timescale 1ns/100ps
module pfi_fault_irq_props (
  // apb
  input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [3:0]  pstrb,
  // events and outputs
  input wire logic [5:0]  event_cond,
  input wire logic [7:0]  fault_cond,
  input wire logic        upper_ov_warn_level_select, interrupt_out_n, system_reset_out_n
);
  logic [7:0] rm_ff;
  logic [5:0] im_ff;
  wire        wr = psel && penable && pwrite && pstrb[0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rm_ff <= 8'h00;
    else if (wr && paddr == 12'h044) rm_ff <= pwdata[7:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) im_ff <= 6'h00;
    else if (wr && paddr == 12'h04C) im_ff <= pwdata[7:2];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rd(a); psel && !penable && !pwrite && paddr == a; endsequence
  sequence s_evt; |event_cond ##1 |($past(event_cond) & ~im_ff); endsequence
  a_sel_follow: assert property (wr && paddr == 12'h040 |=> ##1
    upper_ov_warn_level_select == $past(pwdata[7], 2)) else $error("select wrong");
  a_rst_gate: assert property (1'b1 |=>
    system_reset_out_n == !$past(|(fault_cond & ~rm_ff))) else $error("reset wrong");
  a_irq_raise: assert property (s_evt |=> !interrupt_out_n) else $error("irq missing");
  a_irq_idle: assert property (im_ff == 6'h3F |=> interrupt_out_n) else $error("irq leak");
  a_flag_rsvd: assert property (s_rd(12'h048) |=> prdata[1:0] == 2'h0 && prdata[31:8] == 24'h0)
    else $error("flag bits");
  a_flag_hold: assert property (s_rd(12'h048) |=> !$past(presetn, 2) ||
    (prdata[7:2] & $past(event_cond, 2)) == $past(event_cond, 2)) else $error("flag lost");
  a_imask_read: assert property (s_rd(12'h04C) |=> prdata == {24'h0, im_ff, 2'h0})
    else $error("irq mask");
  a_rmask_read: assert property (s_rd(12'h044) |=> prdata == {24'h0, rm_ff}) else $error("rst mask");
endmodule
bind pfi_fault_irq pfi_fault_irq_props pfi_fault_irq_props_i (.*);

/* tb/pfi_host_model.sv */
// Purpose: apb host model
// Assumes: pready sampled on rising pclk
// Notes: idle edge between transfers
`timescale 1ns/100ps
module pfi_host_model (
  input wire logic pclk, pready,
  output logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0,
  output logic [11:0] paddr = 12'h000,
  output logic [31:0] pwdata = 32'h0,
  output logic [3:0] pstrb = 4'h0
);
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
endmodule

/* tb/tb_top.sv */
// Purpose: self-checking bench for pfi_fault_irq
// Assumes: reads checked from a queue
// Notes: fixed seed
`timescale 1ns/100ps
module tb_top
  import pfi_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  pfi_evt_t event_cond = 6'h00;
  pfi_byte_t fault_cond = 8'h00;
  logic upper_ov_warn_level_select, interrupt_out_n, system_reset_out_n;
  logic [32:0] exp_q[$];
  int err_count = 0, checks = 0;
  pfi_fault_irq pfi_fault_irq_i (.*);
  pfi_host_model pfi_host_model_i (.*);
  initial forever #5 pclk = ~pclk;
  task automatic chk(input logic [32:0] s, e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic conclude;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    pfi_host_model_i.xfer(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    pfi_host_model_i.xfer(1'b1, a, {24'h0, d});
  endtask
  always @(posedge pclk)
    if (psel && penable && !pwrite && pready === 1'b1) chk({pslverr, prdata}, exp_q.pop_front());
  initial begin
    #100000;
    err_count++;
    conclude;
  end
  initial begin
    logic [7:0] r;
    void'($urandom(32'h37ED));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) rd(12'(12'h040 + 4 * i), 33'h0);
    rd(12'h050, 33'h1_0000_0000);
    for (int i = 0; i < 2; i++) begin
      r = {i[0], 7'($urandom)};
      wr(12'h040, r);
      rd(12'h040, {25'h0, r});
      @(negedge pclk) chk(upper_ov_warn_level_select, i[0]);
      @(posedge pclk);
    end
    for (int j = 0; j < 8; j++) begin
      r = 8'($urandom) & ~(8'h01 << j) | (8'(j % 2) << j);
      wr(12'h044, r);
      fault_cond <= 8'h01 << j;
      repeat (2) @(posedge pclk);
      @(negedge pclk) chk(system_reset_out_n, j % 2);
      @(posedge pclk);
      rd(12'h044, {25'h0, r});
    end
    wr(12'h044, 8'hFF);
    fault_cond <= 8'hFF;
    for (int i = 0; i < 6; i++) begin
      r = 8'($urandom) & ~(8'h04 << i) | (8'(i % 2) << (i + 2));
      wr(12'h04C, r);
      rd(12'h04C, {25'h0, r & 8'hFC});
      event_cond <= 6'h01 << i;
      wr(12'h048, 8'hFF);
      wr(12'h048, 8'h00);
      rd(12'h048, {25'h0, 8'h04 << i});
      @(negedge pclk) chk(interrupt_out_n, i % 2);
      chk(system_reset_out_n, 1);
      @(posedge pclk);
      event_cond <= 6'h00;
      wr(12'h048, 8'h04 << i);
      rd(12'h048, 33'h0);
      @(negedge pclk) chk(interrupt_out_n, 1);
      @(posedge pclk);
    end
    conclude;
  end
endmodule
